// *** hdl/ltdc_core.sv ***
// Time digitization core: input latch, two shift chains, holding registers
// What this block does
// R1: Latch feeds two chains of two 8-bit registers
// R2: Each chain keeps twelve meaningful bits per pulse
// R3: Odd chain on true edges, even on complement
// R4: Twelve holding registers per chain, one per bit
// R5: Strobe rising edge captures all holding registers together
// R6: Shift clear empties every shift register
// R7: Hold clear empties all holding registers together
// R8: Twenty-four bins, first starts at strobe
// R9: Strobe resets latch and arms extended busy
// R10: Strobe keeps fixed relation to clock train
// R11: Blind-interval hits still set extended busy
// R12: Bins are train half-periods, first one wider
// R13: True and complement phases from one train
// R14: Gating board supplies and gates the train
// R15: Shift clear follows strobe, never precedes capture
// R16: Clears override shifting and capture, output zero
`timescale 1ns/100ps
`default_nettype none

module ltdc_core (
    input  wire logic                              sys_clk,
    input  wire logic                              srst,
    input  wire logic                              hit_in,
    input  wire logic                              clock_train,
    input  wire logic                              pulse_end_strobe,
    input  wire logic                              shift_chain_clear,
    input  wire logic                              hold_register_clear,
    output logic     [ltdc_pkg::NUM_BINS-1:0]      time_bins,
    output logic                                   extended_busy,
    output logic                                   input_latch,
    output logic                                   blind_hit,
    output logic                                   train_error
);

    // Rising edge of a synchronised level against its delayed copy
    function automatic logic rise_of(input logic cur, input logic prev);
        rise_of = cur & ~prev;
    endfunction

    logic [ltdc_pkg::NUM_PINS-1:0] meta_q;
    logic [ltdc_pkg::NUM_PINS-1:0] sync_q;
    logic [ltdc_pkg::NUM_PINS-1:0] prev_q;

    // Two flip-flops per pin plus a delayed copy; the second stage and the copy are examined, the first never
    genvar gi;
    generate
        for (gi = 0; gi < ltdc_pkg::NUM_PINS; gi++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                    prev_q[gi] <= 1'b0;
                end else begin
                    meta_q[gi] <= gi == ltdc_pkg::PIN_HIT ? hit_in :
                                  gi == ltdc_pkg::PIN_TRAIN ? clock_train :
                                  gi == ltdc_pkg::PIN_STROBE ? pulse_end_strobe :
                                  gi == ltdc_pkg::PIN_SCLR ? shift_chain_clear : hold_register_clear;
                    sync_q[gi] <= meta_q[gi];
                    prev_q[gi] <= sync_q[gi];
                end
            end
        end
    endgenerate

    logic hit_lvl;
    logic true_edge;
    logic comp_edge;
    logic strobe_rise;
    logic sclr_lvl;
    logic hclr_lvl;

    // Both phases come from one train, so they stay exactly opposite
    assign hit_lvl     = sync_q[ltdc_pkg::PIN_HIT];
    assign true_edge   = rise_of(sync_q[ltdc_pkg::PIN_TRAIN], prev_q[ltdc_pkg::PIN_TRAIN]);  // [R13]
    assign comp_edge   = rise_of(prev_q[ltdc_pkg::PIN_TRAIN], sync_q[ltdc_pkg::PIN_TRAIN]);  // [R13]
    assign strobe_rise = rise_of(sync_q[ltdc_pkg::PIN_STROBE], prev_q[ltdc_pkg::PIN_STROBE]);
    assign sclr_lvl    = sync_q[ltdc_pkg::PIN_SCLR];
    assign hclr_lvl    = sync_q[ltdc_pkg::PIN_HCLR];

    logic latch_q;
    logic busy_q;
    logic busy_seen_q;

    // Input latch: set by a hit, held reset under busy, dropped at the strobe
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            latch_q <= 1'b0;
        end else if (strobe_rise || busy_q) begin
            latch_q <= 1'b0; // [R9]
        end else if (hit_lvl) begin
            latch_q <= 1'b1;
        end
    end

    // Busy monitor covers the whole pulse, blind interval included
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busy_seen_q <= 1'b0;
        end else if (strobe_rise) begin
            busy_seen_q <= hit_lvl; // A hit on the strobe cycle counts for the next pulse
        end else if (hit_lvl || latch_q) begin
            busy_seen_q <= 1'b1; // [R11]
        end
    end

    // Extended busy is re-armed once per pulse, on the strobe
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busy_q <= 1'b0;
        end else if (strobe_rise) begin
            busy_q <= busy_seen_q | hit_lvl | latch_q; // [R9] [R11]
        end
    end

    ltdc_pkg::ltdc_phase_t phase_q;
    logic [ltdc_pkg::CNT_W-1:0] odd_cnt_q;
    logic [ltdc_pkg::CNT_W-1:0] even_cnt_q;

    // Edge counters give the pulse phase and let the strobe be checked against the train
    always_ff @(posedge sys_clk) begin
        if (srst || strobe_rise) begin
            odd_cnt_q  <= '0;
            even_cnt_q <= '0;
        end else begin
            if (true_edge && odd_cnt_q != '1) begin
                odd_cnt_q <= odd_cnt_q + 5'h01;
            end
            if (comp_edge && even_cnt_q != '1) begin
                even_cnt_q <= even_cnt_q + 5'h01;
            end
        end
    end

    // First bin runs from the strobe to the first true edge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            phase_q <= ltdc_pkg::PH_WAIT;
        end else begin
            case (phase_q)
                ltdc_pkg::PH_WAIT: begin
                    if (true_edge) begin
                        phase_q <= ltdc_pkg::PH_TRAIN; // [R8]
                    end
                end
                ltdc_pkg::PH_TRAIN: begin
                    if (strobe_rise) begin
                        phase_q <= ltdc_pkg::PH_WAIT;
                    end else if (comp_edge && even_cnt_q == ltdc_pkg::EDGES_PER_PULSE - 5'h01) begin
                        phase_q <= ltdc_pkg::PH_BLIND; // [R2]
                    end
                end
                ltdc_pkg::PH_BLIND: begin
                    if (strobe_rise) begin
                        phase_q <= ltdc_pkg::PH_WAIT;
                    end
                end
                default: begin
                    phase_q <= ltdc_pkg::PH_WAIT;
                end
            endcase
        end
    end

    // Blind-spot hit marker: set wins over the strobe that clears it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            blind_hit <= 1'b0;
        end else if (phase_q == ltdc_pkg::PH_BLIND && hit_lvl) begin
            blind_hit <= 1'b1; // [R9]
        end else if (strobe_rise) begin
            blind_hit <= 1'b0;
        end
    end

    // A strobe that does not follow exactly twelve pulses of each phase is flagged
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            train_error <= 1'b0;
        end else if (strobe_rise) begin
            train_error <= (odd_cnt_q != ltdc_pkg::EDGES_PER_PULSE) ||
                           (even_cnt_q != ltdc_pkg::EDGES_PER_PULSE); // [R10] [R14]
        end
    end

    logic [ltdc_pkg::MEAN_BITS-1:0] odd_bits;
    logic [ltdc_pkg::MEAN_BITS-1:0] even_bits;
    ltdc_pkg::ltdc_pattern_t        held;

    // Odd chain follows the true phase
    ltdc_shift_chain u_odd_chain (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .shift_en (true_edge), // [R3]
        .clear    (sclr_lvl),  // [R6]
        .din      (latch_q),   // [R1]
        .bits     (odd_bits)
    );

    // Even chain follows the complement phase
    ltdc_shift_chain u_even_chain (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .shift_en (comp_edge), // [R3]
        .clear    (sclr_lvl),  // [R6]
        .din      (latch_q),   // [R1]
        .bits     (even_bits)
    );

    // Capture reads chain values from before any clear of the same edge
    ltdc_hold_bank u_odd_hold (
        .sys_clk (sys_clk),
        .srst    (srst),
        .capture (strobe_rise), // [R5] [R15]
        .clear   (hclr_lvl),    // [R7]
        .din     (odd_bits),
        .hold_q  (held.odd)
    );

    ltdc_hold_bank u_even_hold (
        .sys_clk (sys_clk),
        .srst    (srst),
        .capture (strobe_rise), // [R5] [R15]
        .clear   (hclr_lvl),    // [R7]
        .din     (even_bits),
        .hold_q  (held.even)
    );

    // Bin n+1 interleaves odd and even bits, oldest sample first
    generate
        for (gi = 0; gi < ltdc_pkg::MEAN_BITS; gi++) begin : g_bins
            assign time_bins[2*gi]   = held.odd[ltdc_pkg::MEAN_BITS-1-gi];  // [R8] [R12]
            assign time_bins[2*gi+1] = held.even[ltdc_pkg::MEAN_BITS-1-gi]; // [R8] [R12]
        end
    endgenerate

    assign extended_busy = busy_q;
    assign input_latch   = latch_q;

    a_strobe_drops_latch : assert property (@(posedge sys_clk) disable iff (srst) // [R9]
        strobe_rise |=> !latch_q)
        else $error("Input latch survived the strobe");

    a_busy_holds_latch : assert property (@(posedge sys_clk) disable iff (srst) // [R9]
        (busy_q && !strobe_rise) ##1 busy_q |-> !latch_q)
        else $error("Input latch set under extended busy");

    a_busy_arm : assert property (@(posedge sys_clk) disable iff (srst) // [R11]
        (strobe_rise && busy_seen_q) |=> busy_q)
        else $error("Extended busy not armed by earlier hit");

    a_blind_hit_busy : assert property (@(posedge sys_clk) disable iff (srst) // [R11]
        (phase_q == ltdc_pkg::PH_BLIND && hit_lvl && !strobe_rise) |=> busy_seen_q)
        else $error("Blind interval hit lost by busy monitor");

    a_odd_shift_only : assert property (@(posedge sys_clk) disable iff (srst) // [R3]
        (!true_edge && !sclr_lvl) |=> $stable(odd_bits))
        else $error("Odd chain moved without a true edge");

    a_even_shift_only : assert property (@(posedge sys_clk) disable iff (srst) // [R3]
        (!comp_edge && !sclr_lvl) |=> $stable(even_bits))
        else $error("Even chain moved without a complement edge");

    a_hold_clear_all : assert property (@(posedge sys_clk) disable iff (srst) // [R7]
        hclr_lvl |=> (time_bins == '0))
        else $error("Time bins not cleared by hold clear");

    a_capture_pattern : assert property (@(posedge sys_clk) disable iff (srst) // [R5]
        (strobe_rise && !hclr_lvl) |=> (held.odd == $past(odd_bits) && held.even == $past(even_bits)))
        else $error("Strobe did not capture both chains");

    // Each complement edge must trail exactly one true edge; saturated counts are left out
    a_phases_apart : assert property (@(posedge sys_clk) disable iff (srst) // [R13]
        (comp_edge && !strobe_rise && odd_cnt_q != '1) |-> (odd_cnt_q == even_cnt_q + 5'h01))
        else $error("True and complement edges out of step");

    a_first_edge_train : assert property (@(posedge sys_clk) disable iff (srst) // [R8]
        (phase_q == ltdc_pkg::PH_WAIT && true_edge && !strobe_rise) |=> phase_q == ltdc_pkg::PH_TRAIN)
        else $error("First true edge did not start the train");

    a_latch_takes_hit : assert property (@(posedge sys_clk) disable iff (srst) // [R1]
        (hit_lvl && !busy_q && !strobe_rise) |=> latch_q)
        else $error("Input latch missed a hit");

    a_busy_quiet_drop : assert property (@(posedge sys_clk) disable iff (srst) // [R9]
        (strobe_rise && !busy_seen_q && !hit_lvl && !latch_q) |=> !busy_q)
        else $error("Extended busy armed without a hit");

    a_blind_hit_mark : assert property (@(posedge sys_clk) disable iff (srst) // [R9]
        (phase_q == ltdc_pkg::PH_BLIND && hit_lvl) |=> blind_hit)
        else $error("Blind interval hit not marked");

    a_train_count_ok : assert property (@(posedge sys_clk) disable iff (srst) // [R10]
        (strobe_rise && odd_cnt_q == ltdc_pkg::EDGES_PER_PULSE &&
         even_cnt_q == ltdc_pkg::EDGES_PER_PULSE) |=> !train_error)
        else $error("Clock train error flagged on a full train");

    a_train_count_bad : assert property (@(posedge sys_clk) disable iff (srst) // [R10]
        (strobe_rise && (odd_cnt_q != ltdc_pkg::EDGES_PER_PULSE ||
                         even_cnt_q != ltdc_pkg::EDGES_PER_PULSE)) |=> train_error)
        else $error("Clock train error missed on a wrong count");

endmodule

`default_nettype wire

// *** hdl/ltdc_pkg.sv ***
// Shared constants and carrier types for the latching time digitizer core
package ltdc_pkg;

    // Shift chain geometry
    localparam int SR_BITS    = 8;
    localparam int MEAN_BITS  = 12;
    localparam int HIGH_BITS  = MEAN_BITS - SR_BITS;
    localparam int NUM_BINS   = 24;
    localparam int CNT_W      = 5;

    // Edges seen by each chain in one beam pulse
    localparam logic [CNT_W-1:0] EDGES_PER_PULSE = 5'h0c;

    // Positions of the pin inputs in the synchroniser vector
    localparam int PIN_HIT    = 0;
    localparam int PIN_TRAIN  = 1;
    localparam int PIN_STROBE = 2;
    localparam int PIN_SCLR   = 3;
    localparam int PIN_HCLR   = 4;
    localparam int NUM_PINS   = 5;

    // Reset values
    localparam logic [MEAN_BITS-1:0] HOLD_RESET = 12'h000;
    localparam logic [SR_BITS-1:0]   SR_RESET   = 8'h00;

    // Phase of the beam pulse as seen by the core
    typedef enum logic [1:0] {
        PH_WAIT  = 2'b00,
        PH_TRAIN = 2'b01,
        PH_BLIND = 2'b10
    } ltdc_phase_t;

    // Captured pattern of both chains
    typedef struct packed {
        logic [MEAN_BITS-1:0] odd;
        logic [MEAN_BITS-1:0] even;
    } ltdc_pattern_t;

endpackage

// *** hdl/ltdc_shift_chain.sv ***
// One shift chain: two 8-bit shift registers in series
`timescale 1ns/100ps
`default_nettype none

module ltdc_shift_chain (
    input  wire logic                              sys_clk,
    input  wire logic                              srst,
    input  wire logic                              shift_en,
    input  wire logic                              clear,
    input  wire logic                              din,
    output logic     [ltdc_pkg::MEAN_BITS-1:0]     bits
);

    logic [ltdc_pkg::SR_BITS-1:0] first_q;
    logic [ltdc_pkg::SR_BITS-1:0] second_q;

    // Clear dominates shifting while it is held
    always_ff @(posedge sys_clk) begin
        if (srst || clear) begin
            first_q  <= ltdc_pkg::SR_RESET; // [R16]
            second_q <= ltdc_pkg::SR_RESET; // [R6]
        end else if (shift_en) begin
            first_q  <= {first_q[ltdc_pkg::SR_BITS-2:0], din};
            second_q <= {second_q[ltdc_pkg::SR_BITS-2:0], first_q[ltdc_pkg::SR_BITS-1]}; // [R1]
        end
    end

    // Only four bits of the second register carry data after twelve shifts
    assign bits = {second_q[ltdc_pkg::HIGH_BITS-1:0], first_q}; // [R2]

    a_chain_clear_zero : assert property (@(posedge sys_clk) disable iff (srst) // [R16]
        clear |=> (first_q == ltdc_pkg::SR_RESET && second_q == ltdc_pkg::SR_RESET))
        else $error("Shift chain not empty after clear");

endmodule

`default_nettype wire

// *** hdl/ltdc_hold_bank.sv ***
// Twelve holding registers for one chain
`timescale 1ns/100ps
`default_nettype none

module ltdc_hold_bank (
    input  wire logic                              sys_clk,
    input  wire logic                              srst,
    input  wire logic                              capture,
    input  wire logic                              clear,
    input  wire logic [ltdc_pkg::MEAN_BITS-1:0]    din,
    output logic     [ltdc_pkg::MEAN_BITS-1:0]     hold_q
);

    // Clear wins over capture, so a late capture cannot revive stale bits
    always_ff @(posedge sys_clk) begin
        if (srst || clear) begin
            hold_q <= ltdc_pkg::HOLD_RESET; // [R7] [R16]
        end else if (capture) begin
            hold_q <= din; // [R4] [R5]
        end
    end

    a_hold_takes_bits : assert property (@(posedge sys_clk) disable iff (srst) // [R4]
        (capture && !clear) |=> (hold_q == $past(din)))
        else $error("Holding registers missed the chain pattern");

endmodule

`default_nettype wire

// *** verif/ltdc_gating_board.sv ***
// Gating board model: gated train, counted strobe and shift clear per beam pulse
`timescale 1ns/100ps
`default_nettype none

module ltdc_gating_board (
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       start,
    input  wire logic [4:0] n_rise,
    output logic            clock_train,
    output logic            pulse_end_strobe,
    output logic            shift_chain_clear,
    output logic [5:0]      edge_idx,
    output logic            done
);
    initial begin
        clock_train = 1'b0;
        pulse_end_strobe = 1'b0;
        shift_chain_clear = 1'b0;
        edge_idx = 6'h00;
        done = 1'b1;
    end

    // One frame per start request; the train stands low between frames
    always begin
        @(posedge sys_clk);
        if (start && !srst) begin
            #1 done = 1'b0;
            repeat (3) @(posedge sys_clk);
            // Three cycles a level, so the core's synchroniser never drops one
            for (int k = 0; k < 2 * n_rise; k++) begin
                #1 clock_train = ~clock_train;
                edge_idx = 6'(k + 1);
                repeat (3) @(posedge sys_clk);
            end
            // Strobe counted off the train after it is gated low, leaving a blind gap
            repeat (6) @(posedge sys_clk);
            #1 pulse_end_strobe = 1'b1;
            @(posedge sys_clk);
            #1 shift_chain_clear = 1'b1;
            repeat (2) @(posedge sys_clk);
            #1 pulse_end_strobe = 1'b0;
            @(posedge sys_clk);
            #1 shift_chain_clear = 1'b0;
            repeat (4) @(posedge sys_clk);
            #1 edge_idx = 6'h00;
            done = 1'b1;
        end
    end
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the latching time digitizer core
`timescale 1ns/100ps
`default_nettype none

module tb;
    logic        sys_clk;
    logic        srst;
    logic        hit_in;
    logic        hold_register_clear;
    logic        start;
    logic [4:0]  n_rise;
    logic        clock_train;
    logic        pulse_end_strobe;
    logic        shift_chain_clear;
    logic [5:0]  edge_idx;
    logic        done;
    logic [23:0] time_bins;
    logic        extended_busy;
    logic        input_latch;
    logic        blind_hit;
    logic        train_error;
    int          failures;
    int          tests_run;
    int          cycles;

    ltdc_core dut (
        .sys_clk             (sys_clk),
        .srst                (srst),
        .hit_in              (hit_in),
        .clock_train         (clock_train),
        .pulse_end_strobe    (pulse_end_strobe),
        .shift_chain_clear   (shift_chain_clear),
        .hold_register_clear (hold_register_clear),
        .time_bins           (time_bins),
        .extended_busy       (extended_busy),
        .input_latch         (input_latch),
        .blind_hit           (blind_hit),
        .train_error         (train_error)
    );

    ltdc_gating_board board (
        .sys_clk           (sys_clk),
        .srst              (srst),
        .start             (start),
        .n_rise            (n_rise),
        .clock_train       (clock_train),
        .pulse_end_strobe  (pulse_end_strobe),
        .shift_chain_clear (shift_chain_clear),
        .edge_idx          (edge_idx),
        .done              (done)
    );

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish();
        if (failures == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Ceiling far above the few thousand cycles the sequence needs
    always @(posedge sys_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One beam pulse; hk = edge before which the hit lands, 25 = blind gap, 0 = none
    task automatic run_pulse(input logic [4:0] nr, input int hk, input logic [23:0] eb,
                             input logic ebusy, input logic eerr);
        @(posedge sys_clk);
        #1 n_rise = nr;
        start = 1'b1;
        @(posedge sys_clk);
        #1 start = 1'b0;
        // The board drops done on this same step, so poll it only from the next edge on
        @(posedge sys_clk);
        if (hk > 0) begin
            while (edge_idx !== 6'(hk - 1)) @(posedge sys_clk);
            #1 hit_in = 1'b1;
            repeat (4) @(posedge sys_clk);
            #1 hit_in = 1'b0;
            if (hk == 25) begin
                chk({22'h0, blind_hit, input_latch}, 24'h000003, "blind hit latched");
            end
        end
        while (!done) @(posedge sys_clk);
        #1;
        chk(time_bins, eb, "captured bins");
        chk({21'h0, input_latch, extended_busy, train_error}, {22'h0, ebusy, eerr}, "latch busy err");
        hold_register_clear = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1 chk(time_bins, 24'h000000, "hold clear");
        hold_register_clear = 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic t_reset();
        chk(time_bins, 24'h000000, "reset bins");
        chk({20'h0, extended_busy, input_latch, blind_hit, train_error}, 24'h000000, "reset flags");
    endtask

    // Hit at each boundary bin, then a quiet pulse to let busy fall
    task automatic t_bins();
        int ks [8] = '{1, 2, 7, 12, 13, 23, 24, 25};
        foreach (ks[i]) begin
            run_pulse(5'h0c, ks[i], (ks[i] > 24) ? 24'h000000 : 24'hffffff << (ks[i] - 1), 1'b1, 1'b0);
            run_pulse(5'h0c, 0, 24'h000000, 1'b0, 1'b0);
        end
    endtask

    // Busy from one pulse refuses the latch in the next
    task automatic t_busy();
        run_pulse(5'h0c, 5, 24'hfffff0, 1'b1, 1'b0);
        run_pulse(5'h0c, 5, 24'h000000, 1'b1, 1'b0);
        run_pulse(5'h0c, 0, 24'h000000, 1'b0, 1'b0);
    endtask

    task automatic t_train();
        run_pulse(5'h0b, 0, 24'h000000, 1'b0, 1'b1);
        run_pulse(5'h0d, 0, 24'h000000, 1'b0, 1'b1);
        run_pulse(5'h0c, 0, 24'h000000, 1'b0, 1'b0);
    endtask

    // A strobe with no train must not recapture the earlier pattern
    task automatic t_chain_clear();
        run_pulse(5'h0c, 3, 24'hfffffc, 1'b1, 1'b0);
        run_pulse(5'h00, 0, 24'h000000, 1'b0, 1'b1);
    endtask

    initial begin
        failures = 0;
        tests_run = 0;
        cycles = 0;
        srst = 1'b1;
        hit_in = 1'b0;
        hold_register_clear = 1'b0;
        start = 1'b0;
        n_rise = 5'h0c;
        repeat (6) @(posedge sys_clk);
        #1 srst = 1'b0;
        @(posedge sys_clk);
        #1;
        t_reset();
        t_bins();
        t_busy();
        t_train();
        t_chain_clear();
        tally_and_finish();
    end
endmodule
`default_nettype wire
